// ---- rtl/exception_routing_binding_pkg.sv ----
// Register map, reset values and select codes of the exception router
`default_nettype none
package exception_routing_binding_pkg;
  localparam int EVENT_COUNT = 24;

  // Register indices; the bus byte address is four times the index
  localparam logic [5:0] IDX_FLAG_LO = 6'h10;
  localparam logic [5:0] IDX_FLAG_MID = 6'h11;
  localparam logic [5:0] IDX_FLAG_HI = 6'h12;
  localparam logic [5:0] IDX_CHAN_A_LO = 6'h14;
  localparam logic [5:0] IDX_CHAN_A_MID = 6'h15;
  localparam logic [5:0] IDX_CHAN_A_HI = 6'h16;
  localparam logic [5:0] IDX_CHAN_B_LO = 6'h18;
  localparam logic [5:0] IDX_CHAN_B_MID = 6'h19;
  localparam logic [5:0] IDX_CHAN_B_HI = 6'h1a;
  localparam logic [5:0] IDX_BIND_X_INSTR = 6'h1c;
  localparam logic [5:0] IDX_BIND_X_EVENT = 6'h1d;
  localparam logic [5:0] IDX_BIND_Y_INSTR = 6'h1e;
  localparam logic [5:0] IDX_BIND_Y_EVENT = 6'h1f;
  localparam logic [5:0] IDX_PIN0_CONTROL = 6'h20;
  localparam logic [5:0] IDX_PIN_POLARITY = 6'h26;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h30;
  localparam logic [5:0] IDX_IRQ_CLEAR = 6'h31;
  localparam logic [5:0] IDX_IRQ_ENABLE = 6'h32;

  // Field positions
  localparam int BIND_ENABLE_BIT = 7;
  localparam int PIN0_DIR_BIT = 7;
  localparam int IRQ_BIND_X = 0;
  localparam int IRQ_BIND_Y = 1;
  localparam int IRQ_PIN0 = 2;
  localparam int IRQ_COUNT = 3;

  // Values after reset
  localparam logic [23:0] MASK_RESET = 24'h000000;
  localparam logic [3:0] INSTR_RESET = 4'h0;
  localparam logic [4:0] EVENT_NUM_RESET = 5'h12;
  localparam logic [6:0] PIN0_CONFIG_RESET = 7'h00;
  localparam logic PIN0_POLARITY_RESET = 1'b1;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // Highest input configuration that still selects an instruction
  localparam logic [6:0] PIN0_INSTR_MAX = 7'h0f;

  // Output select codes that carry the channel indications
  localparam logic [6:0] SEL_CHAN_A = 7'h21;
  localparam logic [6:0] SEL_CHAN_A_COMP = 7'h22;
  localparam logic [6:0] SEL_CHAN_B = 7'h23;
  localparam logic [6:0] SEL_CHAN_B_COMP = 7'h24;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ANSWER = 2'b10
  } bus_state_t;
endpackage : exception_routing_binding_pkg
`default_nettype wire

// ---- rtl/exception_routing_binding.sv ----
// Exception routing to pin 0, exception-to-instruction binding, pin 0 control
`default_nettype none
module exception_routing_binding (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Exception occurrences, one cycle each
  input wire logic [23:0] eventPulse,
  // Other internal signals selectable on pin 0
  input wire logic [127:0] internalSignals,
  // Pin 0
  input wire logic pin0In,
  output logic pin0Out,
  output logic pin0Oe,
  // Channel indications: A, A complement, B, B complement
  output logic [3:0] chanIndication,
  // Instruction triggers
  output logic bindXFire,
  output logic [3:0] bindXInstr,
  output logic bindYFire,
  output logic [3:0] bindYInstr,
  output logic pin0Fire,
  output logic [3:0] pin0Instr,
  // Interrupt
  output logic irq
);

  // Any selected event in this cycle
  function automatic logic chanHit(input logic [23:0] ev,
                                   input logic [23:0] sel);
    chanHit = |(ev & sel);
  endfunction : chanHit

  // Event number beyond the event set never matches
  function automatic logic bindHit(input logic en, input logic [4:0] num,
                                   input logic [23:0] ev);
    logic hit;
    hit = 1'b0;
    if (en && num < 5'd24) begin
      hit = ev[num];
    end
    bindHit = hit;
  endfunction : bindHit

  exception_routing_binding_pkg::bus_state_t busState_q;
  exception_routing_binding_pkg::bus_state_t busState_d;
  logic [5:0] regIndex;
  logic wrEn;
  logic [7:0] wrByte;
  logic [7:0] rdByte;
  logic [23:0] chanAMask_q;
  logic [23:0] chanBMask_q;
  logic [23:0] pendingFlags_q;
  logic [3:0] bindXInstrNum_q;
  logic [4:0] bindXEventNum_q;
  logic bindXEnable_q;
  logic [3:0] bindYInstrNum_q;
  logic [4:0] bindYEventNum_q;
  logic bindYEnable_q;
  logic pin0IsInput_q;
  logic [6:0] pin0Config_q;
  logic pinPolarity_q;
  logic [2:0] irqStatus_q;
  logic [2:0] irqEnable_q;
  logic [2:0] irqEvents;
  logic [3:0] chanNow;
  logic [127:0] outChoices;
  logic pin0Prev_q;
  logic pin0PrevValid_q;
  logic pin0Edge;
  logic pin0Trigger;
  logic bindXHit;
  logic bindYHit;

  // Bus: one wait cycle, then answer; the read byte is captured meanwhile
  assign regIndex = avs_address[7:2];
  assign wrByte = avs_writedata[7:0];
  assign wrEn = busState_q == exception_routing_binding_pkg::BUS_ANSWER &&
                avs_write && avs_byteenable[0];

  always_comb begin
    busState_d = busState_q;
    unique case (busState_q)
      exception_routing_binding_pkg::BUS_IDLE: begin
        if (avs_read || avs_write) begin
          busState_d = exception_routing_binding_pkg::BUS_ANSWER;
        end
      end
      exception_routing_binding_pkg::BUS_ANSWER: begin
        busState_d = exception_routing_binding_pkg::BUS_IDLE;
      end
      default: begin
        busState_d = exception_routing_binding_pkg::BUS_IDLE;
      end
    endcase
  end

  always_comb begin
    avs_waitrequest = (avs_read || avs_write) &&
                      busState_q != exception_routing_binding_pkg::BUS_ANSWER;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      busState_q <= exception_routing_binding_pkg::BUS_IDLE;
    end else begin
      busState_q <= busState_d;
    end
  end

  // Reserved bits and unmapped indices read as zero
  always_comb begin
    rdByte = 8'h00;
    unique case (regIndex)
      exception_routing_binding_pkg::IDX_FLAG_LO: rdByte = pendingFlags_q[7:0];
      exception_routing_binding_pkg::IDX_FLAG_MID:
        rdByte = pendingFlags_q[15:8];
      exception_routing_binding_pkg::IDX_FLAG_HI:
        rdByte = pendingFlags_q[23:16];
      exception_routing_binding_pkg::IDX_CHAN_A_LO: rdByte = chanAMask_q[7:0];
      exception_routing_binding_pkg::IDX_CHAN_A_MID: rdByte = chanAMask_q[15:8];
      exception_routing_binding_pkg::IDX_CHAN_A_HI: rdByte = chanAMask_q[23:16];
      exception_routing_binding_pkg::IDX_CHAN_B_LO: rdByte = chanBMask_q[7:0];
      exception_routing_binding_pkg::IDX_CHAN_B_MID: rdByte = chanBMask_q[15:8];
      exception_routing_binding_pkg::IDX_CHAN_B_HI: rdByte = chanBMask_q[23:16];
      exception_routing_binding_pkg::IDX_BIND_X_INSTR:
        rdByte = {4'h0, bindXInstrNum_q};
      exception_routing_binding_pkg::IDX_BIND_X_EVENT:
        rdByte = {bindXEnable_q, 2'b00, bindXEventNum_q};
      exception_routing_binding_pkg::IDX_BIND_Y_INSTR:
        rdByte = {4'h0, bindYInstrNum_q};
      exception_routing_binding_pkg::IDX_BIND_Y_EVENT:
        rdByte = {bindYEnable_q, 2'b00, bindYEventNum_q};
      exception_routing_binding_pkg::IDX_PIN0_CONTROL:
        rdByte = {pin0IsInput_q, pin0Config_q};
      exception_routing_binding_pkg::IDX_PIN_POLARITY:
        rdByte = {7'h00, pinPolarity_q};
      exception_routing_binding_pkg::IDX_IRQ_STATUS:
        rdByte = {5'h00, irqStatus_q};
      exception_routing_binding_pkg::IDX_IRQ_ENABLE:
        rdByte = {5'h00, irqEnable_q};
      default: rdByte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h00000000;
    end else if (busState_q == exception_routing_binding_pkg::BUS_IDLE &&
                 avs_read) begin
      avs_readdata <= {24'h000000, rdByte};
    end
  end

  // Selection masks
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      chanAMask_q <= exception_routing_binding_pkg::MASK_RESET;
      chanBMask_q <= exception_routing_binding_pkg::MASK_RESET;
    end else if (wrEn) begin
      unique case (regIndex)
        exception_routing_binding_pkg::IDX_CHAN_A_LO:
          chanAMask_q[7:0] <= wrByte;
        exception_routing_binding_pkg::IDX_CHAN_A_MID:
          chanAMask_q[15:8] <= wrByte;
        exception_routing_binding_pkg::IDX_CHAN_A_HI:
          chanAMask_q[23:16] <= wrByte;
        exception_routing_binding_pkg::IDX_CHAN_B_LO:
          chanBMask_q[7:0] <= wrByte;
        exception_routing_binding_pkg::IDX_CHAN_B_MID:
          chanBMask_q[15:8] <= wrByte;
        exception_routing_binding_pkg::IDX_CHAN_B_HI:
          chanBMask_q[23:16] <= wrByte;
        default: begin
        end
      endcase
    end
  end

  // Binding registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bindXInstrNum_q <= exception_routing_binding_pkg::INSTR_RESET;
      bindXEventNum_q <= exception_routing_binding_pkg::EVENT_NUM_RESET;
      bindXEnable_q <= 1'b0;
      bindYInstrNum_q <= exception_routing_binding_pkg::INSTR_RESET;
      bindYEventNum_q <= exception_routing_binding_pkg::EVENT_NUM_RESET;
      bindYEnable_q <= 1'b0;
    end else if (wrEn) begin
      unique case (regIndex)
        exception_routing_binding_pkg::IDX_BIND_X_INSTR:
          bindXInstrNum_q <= wrByte[3:0];
        exception_routing_binding_pkg::IDX_BIND_X_EVENT: begin
          bindXEventNum_q <= wrByte[4:0];
          bindXEnable_q <=
            wrByte[exception_routing_binding_pkg::BIND_ENABLE_BIT];
        end
        exception_routing_binding_pkg::IDX_BIND_Y_INSTR:
          bindYInstrNum_q <= wrByte[3:0];
        exception_routing_binding_pkg::IDX_BIND_Y_EVENT: begin
          bindYEventNum_q <= wrByte[4:0];
          bindYEnable_q <=
            wrByte[exception_routing_binding_pkg::BIND_ENABLE_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // Pin 0 control and polarity
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin0IsInput_q <= 1'b0;
      pin0Config_q <= exception_routing_binding_pkg::PIN0_CONFIG_RESET;
      pinPolarity_q <= exception_routing_binding_pkg::PIN0_POLARITY_RESET;
    end else if (wrEn) begin
      if (regIndex == exception_routing_binding_pkg::IDX_PIN0_CONTROL) begin
        pin0IsInput_q <= wrByte[exception_routing_binding_pkg::PIN0_DIR_BIT];
        pin0Config_q <= wrByte[6:0];
      end
      if (regIndex == exception_routing_binding_pkg::IDX_PIN_POLARITY) begin
        pinPolarity_q <= wrByte[0];
      end
    end
  end

  // Pending flags: a write of zero clears, an event in the same cycle wins
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pendingFlags_q <= 24'h000000;
    end else begin
      for (int b = 0; b < 3; b++) begin
        if (wrEn && regIndex == exception_routing_binding_pkg::IDX_FLAG_LO +
                    6'(b)) begin
          pendingFlags_q[b*8 +: 8] <= (pendingFlags_q[b*8 +: 8] & wrByte) |
                                      eventPulse[b*8 +: 8];
        end else begin
          pendingFlags_q[b*8 +: 8] <= pendingFlags_q[b*8 +: 8] |
                                      eventPulse[b*8 +: 8];
        end
      end
    end
  end

  // Channel indications
  always_comb begin
    chanNow[0] = chanHit(eventPulse, chanAMask_q);
    chanNow[1] = chanHit(eventPulse, ~chanAMask_q);
    chanNow[2] = chanHit(eventPulse, chanBMask_q);
    chanNow[3] = chanHit(eventPulse, ~chanBMask_q);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      chanIndication <= 4'h0;
    end else begin
      chanIndication <= chanNow;
    end
  end

  // Pin 0 output mux; channel codes override the generic signal list
  always_comb begin
    outChoices = internalSignals;
    outChoices[exception_routing_binding_pkg::SEL_CHAN_A] = chanNow[0];
    outChoices[exception_routing_binding_pkg::SEL_CHAN_A_COMP] =
      chanNow[1];
    outChoices[exception_routing_binding_pkg::SEL_CHAN_B] = chanNow[2];
    outChoices[exception_routing_binding_pkg::SEL_CHAN_B_COMP] =
      chanNow[3];
  end

  // An input pin is released; the outside drives it
  always_comb begin
    pin0Oe = !pin0IsInput_q;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin0Out <= 1'b0;
    end else if (!pin0IsInput_q) begin
      pin0Out <= outChoices[pin0Config_q];
    end else begin
      pin0Out <= 1'b0;
    end
  end

  // Edge detection; the first sample after reset cannot form an edge
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin0Prev_q <= 1'b0;
      pin0PrevValid_q <= 1'b0;
    end else begin
      pin0Prev_q <= pin0In;
      pin0PrevValid_q <= 1'b1;
    end
  end

  always_comb begin
    if (pinPolarity_q) begin
      pin0Edge = pin0PrevValid_q && !pin0Prev_q && pin0In;
    end else begin
      pin0Edge = pin0PrevValid_q && pin0Prev_q && !pin0In;
    end
    pin0Trigger = pin0IsInput_q && pin0Edge &&
      pin0Config_q <= exception_routing_binding_pkg::PIN0_INSTR_MAX;
    bindXHit = bindHit(bindXEnable_q, bindXEventNum_q, eventPulse);
    bindYHit = bindHit(bindYEnable_q, bindYEventNum_q, eventPulse);
  end

  // Instruction triggers, one cycle after the cause
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bindXFire <= 1'b0;
      bindXInstr <= 4'h0;
      bindYFire <= 1'b0;
      bindYInstr <= 4'h0;
      pin0Fire <= 1'b0;
      pin0Instr <= 4'h0;
    end else begin
      bindXFire <= bindXHit;
      bindXInstr <= bindXInstrNum_q;
      bindYFire <= bindYHit;
      bindYInstr <= bindYInstrNum_q;
      pin0Fire <= pin0Trigger;
      pin0Instr <= pin0Config_q[3:0];
    end
  end

  // Interrupt status: set beats a clear in the same cycle
  always_comb begin
    irqEvents = 3'h0;
    irqEvents[exception_routing_binding_pkg::IRQ_BIND_X] = bindXHit;
    irqEvents[exception_routing_binding_pkg::IRQ_BIND_Y] = bindYHit;
    irqEvents[exception_routing_binding_pkg::IRQ_PIN0] = pin0Trigger;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irqStatus_q <= exception_routing_binding_pkg::IRQ_RESET;
    end else if (wrEn &&
                 regIndex == exception_routing_binding_pkg::IDX_IRQ_CLEAR) begin
      irqStatus_q <= (irqStatus_q & ~wrByte[2:0]) | irqEvents;
    end else begin
      irqStatus_q <= irqStatus_q | irqEvents;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irqEnable_q <= exception_routing_binding_pkg::IRQ_RESET;
    end else if (wrEn && regIndex ==
                 exception_routing_binding_pkg::IDX_IRQ_ENABLE) begin
      irqEnable_q <= wrByte[2:0];
    end
  end

  always_comb begin
    irq = |(irqStatus_q & irqEnable_q);
  end

endmodule : exception_routing_binding
`default_nettype wire

// ---- dv/exception_routing_binding_chk.sv ----
// Port-level assertions of the exception router
`default_nettype none
module exception_routing_binding_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Events, pin and triggers
  input wire logic [23:0] eventPulse,
  input wire logic pin0In,
  input wire logic pin0Out,
  input wire logic pin0Oe,
  input wire logic [3:0] chanIndication,
  input wire logic bindXFire,
  input wire logic bindYFire,
  input wire logic pin0Fire
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_wait_one:
    assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("bus wait longer than one cycle");
  a_wait_idle:
    assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("wait raised without request");
  a_read_upper:
    assert property (avs_readdata[31:8] == 24'h0)
      else $error("upper read data not zero");
  a_bind_x_cause:
    assert property (bindXFire |-> $past(eventPulse) != 24'h0)
      else $error("bind x fired without event");
  a_bind_y_cause:
    assert property (bindYFire |-> $past(eventPulse) != 24'h0)
      else $error("bind y fired without event");
  a_chan_cover:
    assert property ((chanIndication[0] | chanIndication[1]) ==
      (|$past(eventPulse)) && (chanIndication[2] | chanIndication[3]) ==
      (|$past(eventPulse))) else $error("channel pair not covering events");
  a_pin_released:
    assert property (!pin0Oe && $past(!pin0Oe) |-> !pin0Out)
      else $error("pin output active while input");
  a_pin_fire_dir:
    assert property (pin0Fire |-> $past(!pin0Oe))
      else $error("pin trigger while output");
  a_pin_edge_seen:
    assert property (pin0Fire |-> $past(pin0In) != $past(pin0In, 2))
      else $error("pin trigger without edge");
endmodule : exception_routing_binding_chk
bind exception_routing_binding exception_routing_binding_chk
  exception_routing_binding_chk_inst (.clk_sys, .resetn, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .eventPulse, .pin0In,
  .pin0Out, .pin0Oe, .chanIndication, .bindXFire, .bindYFire, .pin0Fire);
`default_nettype wire

// ---- dv/host_pin_model.sv ----
// Host controller side of pin 0
`default_nettype none
module host_pin_model (
  // Device side of the pad
  input wire logic pin0Oe,
  input wire logic pin0Out,
  // Host level and resolved pad
  input wire logic hostLevel,
  output logic pin0Wire
);
  timeunit 1ns;
  timeprecision 1ps;
  // Host drives only while the pin is an input, so no contention
  assign pin0Wire = pin0Oe ? pin0Out : hostLevel;
endmodule : host_pin_model
`default_nettype wire

// ---- dv/exception_routing_binding_tb.sv ----
// Self-checking bench of the exception router
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module exception_routing_binding_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] RIDX [11] = '{6'h14, 6'h15, 6'h16, 6'h18, 6'h19,
    6'h1a, 6'h1c, 6'h1d, 6'h1e, 6'h1f, 6'h20};
  localparam logic [7:0] RRST [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h12, 8'h00, 8'h12, 8'h00};
  localparam logic [7:0] RONE [11] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'h0f, 8'h9f, 8'h0f, 8'h9f, 8'hff};
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [23:0] eventPulse = 24'h0;
  logic [127:0] internalSignals = 128'h0;
  logic pin0In, pin0Out, pin0Oe, irq, bindXFire, bindYFire, pin0Fire;
  logic [3:0] chanIndication, bindXInstr, bindYInstr, pin0Instr, e4;
  logic hostLevel = 1'b0;
  logic [31:0] rnd = 32'h0083;
  logic [23:0] maskA, maskB, ev;
  logic [127:0] sigVal;
  logic [6:0] code;
  logic [7:0] q;
  int err_total = 0;
  int checks = 0;
  always #10 clk_sys = ~clk_sys;
  exception_routing_binding exception_routing_binding_inst (.clk_sys,
    .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .eventPulse,
    .internalSignals, .pin0In, .pin0Out, .pin0Oe, .chanIndication,
    .bindXFire, .bindXInstr, .bindYFire, .bindYInstr, .pin0Fire,
    .pin0Instr, .irq);
  host_pin_model host_pin_model_inst (.pin0Oe, .pin0Out, .hostLevel,
    .pin0Wire(pin0In));
  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsrNext
  function automatic logic [3:0] chanExp(input logic [23:0] e, a, b);
    return {|(e & ~b), |(e & b), |(e & ~a), |(e & a)};
  endfunction : chanExp
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  // Holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [5:0] i,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= {i, 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h0, d};
    #1;
    while (avs_waitrequest && n < 20) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (avs_waitrequest) begin
      err_total++;
      stop_test();
    end
    @(posedge clk_sys);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wr24(input logic [5:0] i, input logic [23:0] v);
    for (int k = 0; k < 3; k++)
      bus(1'b1, i + 6'(k), v[8*k +: 8]);
  endtask : wr24
  task automatic chk24(input logic [5:0] i, input logic [23:0] v);
    for (int k = 0; k < 3; k++) begin
      bus(1'b0, i + 6'(k), 8'h00);
      `CHK(q, v[8*k +: 8])
    end
  endtask : chk24
  task automatic evPulse(input logic [23:0] v);
    @(posedge clk_sys);
    eventPulse <= v;
    @(posedge clk_sys);
    eventPulse <= 24'h0;
    #1;
  endtask : evPulse
  // The new level forms the edge at the next clock; the trigger stands after it
  task automatic pinEdge(input logic lvl);
    @(posedge clk_sys);
    hostLevel <= lvl;
    @(posedge clk_sys);
    #1;
  endtask : pinEdge
  initial begin
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      bus(1'b0, RIDX[i], 8'h00);
      `CHK(q, RRST[i])
    end
    for (int i = 0; i < 11; i++) begin
      bus(1'b1, RIDX[i], 8'hff);
      bus(1'b0, RIDX[i], 8'h00);
      `CHK(q, RONE[i])
    end
    bus(1'b0, 6'h3f, 8'h00);
    `CHK(q, 8'h00)
    avs_byteenable <= 4'h0;
    bus(1'b1, 6'h14, 8'h00);
    avs_byteenable <= 4'h1;
    bus(1'b0, 6'h14, 8'h00);
    `CHK(q, 8'hff)
    maskA = rnd[23:0];
    maskB = 24'(lfsrNext(rnd) ^ 32'h005a5a5a);
    rnd = lfsrNext(lfsrNext(rnd));
    wr24(6'h14, maskA);
    wr24(6'h18, maskB);
    chk24(6'h14, maskA);
    chk24(6'h18, maskB);
    // Binding event numbers are 0x1f here, so no trigger may occur
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, 6'h20, 8'h21 + 8'(c));
      for (int j = 0; j < 8; j++) begin
        ev = (j == 0) ? 24'hffffff : rnd[23:0] & rnd[31:8];
        rnd = lfsrNext(rnd);
        evPulse(ev);
        e4 = chanExp(ev, maskA, maskB);
        `CHK(chanIndication, e4)
        `CHK(pin0Out, e4[c])
        `CHK(bindXFire, 1'b0)
      end
    end
    code = 7'h01 + {3'b000, rnd[3:0]};
    bus(1'b1, 6'h20, {1'b0, code});
    sigVal = {4{rnd}};
    internalSignals <= sigVal;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK(pin0Out, sigVal[code])
    wr24(6'h10, 24'h0);
    bus(1'b1, 6'h1c, 8'h05);
    bus(1'b1, 6'h1d, 8'h87);
    bus(1'b1, 6'h1e, 8'h0a);
    bus(1'b1, 6'h1f, 8'h17);
    bus(1'b1, 6'h32, 8'h07);
    evPulse(24'h000080);
    `CHK(bindXFire, 1'b1)
    `CHK(bindXInstr, 4'h5)
    `CHK(irq, 1'b1)
    evPulse(24'h800000);
    `CHK(bindYFire, 1'b0)
    bus(1'b1, 6'h1f, 8'h97);
    evPulse(24'h800080);
    `CHK(bindYFire, 1'b1)
    `CHK(bindYInstr, 4'ha)
    `CHK(bindXFire, 1'b1)
    bus(1'b0, 6'h30, 8'h00);
    `CHK(q, 8'h03)
    bus(1'b1, 6'h31, 8'h01);
    bus(1'b0, 6'h30, 8'h00);
    `CHK(q, 8'h02)
    bus(1'b1, 6'h32, 8'h01);
    #1;
    `CHK(irq, 1'b0)
    bus(1'b1, 6'h1d, 8'h07);
    evPulse(24'h000080);
    `CHK(bindXFire, 1'b0)
    bus(1'b1, 6'h10, 8'hff);
    bus(1'b0, 6'h10, 8'h00);
    `CHK(q, 8'h80)
    bus(1'b1, 6'h10, 8'h00);
    bus(1'b0, 6'h10, 8'h00);
    `CHK(q, 8'h00)
    bus(1'b1, 6'h20, 8'h83);
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK(pin0Oe, 1'b0)
    pinEdge(1'b1);
    `CHK(pin0Fire, 1'b1)
    `CHK(pin0Instr, 4'h3)
    pinEdge(1'b0);
    `CHK(pin0Fire, 1'b0)
    bus(1'b1, 6'h26, 8'h00);
    for (int i = 0; i < 16; i++) begin
      bus(1'b1, 6'h20, 8'h80 | 8'(i));
      pinEdge(1'b1);
      `CHK(pin0Fire, 1'b0)
      pinEdge(1'b0);
      `CHK(pin0Fire, 1'b1)
      `CHK(pin0Instr, 4'(i))
    end
    bus(1'b1, 6'h20, 8'h90);
    pinEdge(1'b1);
    pinEdge(1'b0);
    `CHK(pin0Fire, 1'b0)
    // Pin triggers added bit 2; bind Y stays set, bind X was cleared
    bus(1'b0, 6'h30, 8'h00);
    `CHK(q, 8'h06)
    stop_test();
  end
endmodule : exception_routing_binding_tb
`default_nettype wire
